// File: verilog/wta_pkg.sv
// Package of register map, field positions and timing counts for the wake-up timer block.
package wta_pkg;

    // ==========================================================================
    // Register map
    localparam logic [7:0] WTA_ADDR_AUX = 8'h30;
    localparam logic [7:0] WTA_ADDR_WTC = 8'h31;
    localparam logic [7:0] WTA_ADDR_CFG = 8'h32;
    localparam logic [7:0] WTA_ADDR_BASE = 8'h33;
    localparam logic [7:0] WTA_ADDR_AVG = 8'h34;
    localparam logic [7:0] WTA_RST_VAL = 8'h00;

    // ==========================================================================
    // Field positions
    localparam int WTA_WTC_RANGE = 7;
    localparam int WTA_WTC_CODE_MSB = 6;
    localparam int WTA_WTC_CODE_LSB = 4;
    localparam int WTA_WTC_IRQ_TMO = 3;
    localparam int WTA_WTC_AMP = 2;
    localparam int WTA_WTC_PHS = 1;
    localparam int WTA_CFG_THR_MSB = 7;
    localparam int WTA_CFG_THR_LSB = 4;
    localparam int WTA_CFG_INCL = 3;
    localparam int WTA_CFG_WGT_HI = 2;
    localparam int WTA_CFG_WGT_LO = 1;
    localparam int WTA_CFG_AVG_SEL = 0;
    localparam logic [7:0] WTA_WTC_WMASK = 8'hfe;

    // ==========================================================================
    // Timing
    localparam int WTA_CLK_HZ = 40000000;
    localparam int WTA_TICK_MS = 10;
    localparam int WTA_TICK_CYC = WTA_CLK_HZ / 1000 * WTA_TICK_MS;
    localparam int WTA_LONG_MS = 100;
    localparam int WTA_TICKS_LONG = WTA_LONG_MS / WTA_TICK_MS;

    // Live status inputs gathered for the auxiliary display.
    typedef struct packed {
        logic phase_channel;
        logic field_detected;
        logic tx_active;
        logic osc_stable;
        logic rx_enabled;
        logic rx_receiving;
        logic peer_detect_mode;
        logic collision_avoid_active;
    } wta_status_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wta_reg_req_t;

endpackage

// File: verilog/wta_average.sv
// Auto-averaging filter for amplitude measurement results.
`timescale 1ns/100ps
module wta_average
    import wta_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic update,
    input wire logic [1:0] weight_sel,
    input wire logic [7:0] sample,
    output logic [7:0] average
);

    logic [7:0] avg_r;
    logic [8:0] diff;
    logic [8:0] step;

    // Signed difference shifted by 2 to 5; arithmetic shift keeps the sign.
    assign diff = {1'b0, sample} - {1'b0, avg_r};
    assign step = 9'($signed(diff) >>> (3'd2 + {1'b0, weight_sel}));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            avg_r <= WTA_RST_VAL;
        else if (clear)
            avg_r <= WTA_RST_VAL;
        else if (update)
            avg_r <= avg_r + step[7:0]; // see RQ20 RQ16
    end

    assign average = avg_r;

endmodule

// File: verilog/wta_top.sv
// Wake-up timer with amplitude check and auxiliary status display.
`timescale 1ns/100ps

// What this block does
// RQ1: Bit 7 channel, bit 6 field detector.
// RQ2: Bit 5 shows transmitter active.
// RQ3: Bit 4 shows oscillator stable.
// RQ4: Bit 3 shows receive decoder enabled.
// RQ5: Bit 2 shows message being received.
// RQ6: Bit 1 shows peer detection mode.
// RQ7: Bit 0 shows collision avoidance mode.
// RQ8: Read-only displays zero after reset, default.
// RQ9: Writable registers reset to zero.
// RQ10: Period is code plus one times range.
// RQ11: Timeout interrupt at every expiry when enabled.
// RQ12: Amplitude measurement per expiry, interrupt on excess.
// RQ13: Phase measurement request per expiry; bit 0 zero.
// RQ14: Config bits 7..4 give difference threshold.
// RQ15: Bit 3 includes triggering sample in average.
// RQ16: Bits 2..1 pick weight 4 to 32.
// RQ17: Bit 0 selects average or stored baseline.
// RQ18: Readable writable 8-bit baseline value.
// RQ19: Running average shown read-only.
// RQ20: Average moves by difference over weight.
// RQ21: Absolute difference against low-aligned threshold.
module wta_top
    import wta_pkg::*;
#(
    parameter int TICK_CYCLES = WTA_TICK_CYC
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic set_default,
    input wire wta_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire wta_status_t live_status,
    output logic amp_meas_start,
    output logic phase_meas_start,
    input wire logic amp_meas_done,
    input wire logic [7:0] amp_meas_result,
    output logic irq_timeout,
    output logic irq_amplitude
);

    // ==========================================================================
    // Reset release
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_n = rst_sync_r[1];

    // ==========================================================================
    // Registers
    logic [7:0] wtc_r;
    logic [7:0] cfg_r;
    logic [7:0] base_r;
    logic [7:0] aux_r;
    logic [7:0] avg;
    logic [7:0] rdata_r;

    function automatic logic hit(input wta_reg_req_t req, input logic [7:0] a);
        hit = req.we && (req.addr == a);
    endfunction

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wtc_r <= WTA_RST_VAL;
        else if (set_default)
            wtc_r <= WTA_RST_VAL; // see RQ9
        else if (hit(reg_req, WTA_ADDR_WTC))
            wtc_r <= reg_req.wdata & WTA_WTC_WMASK; // see RQ13
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= WTA_RST_VAL;
        else if (set_default)
            cfg_r <= WTA_RST_VAL; // see RQ9
        else if (hit(reg_req, WTA_ADDR_CFG))
            cfg_r <= reg_req.wdata;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            base_r <= WTA_RST_VAL;
        else if (set_default)
            base_r <= WTA_RST_VAL; // see RQ9
        else if (hit(reg_req, WTA_ADDR_BASE))
            base_r <= reg_req.wdata; // see RQ18
    end

    // Live bits are sampled each cycle so the display is one clock behind the pins.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            aux_r <= WTA_RST_VAL;
        else if (set_default)
            aux_r <= WTA_RST_VAL; // see RQ8
        else
            aux_r <= live_status; // see RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= WTA_RST_VAL;
        else if (reg_req.re)
        begin
            if (reg_req.addr == WTA_ADDR_AUX)
                rdata_r <= aux_r;
            else if (reg_req.addr == WTA_ADDR_WTC)
                rdata_r <= wtc_r;
            else if (reg_req.addr == WTA_ADDR_CFG)
                rdata_r <= cfg_r;
            else if (reg_req.addr == WTA_ADDR_BASE)
                rdata_r <= base_r;
            else if (reg_req.addr == WTA_ADDR_AVG)
                rdata_r <= avg; // see RQ19
            else
                rdata_r <= WTA_RST_VAL;
        end
    end

    assign reg_rdata = rdata_r;

    // ==========================================================================
    // Wake-up timer
    logic [31:0] div_r;
    logic tick;
    logic [3:0] tick_cnt_r;
    logic [3:0] sub_cnt_r;
    logic [3:0] sub_len;
    logic expire;
    logic wtc_write;

    assign wtc_write = hit(reg_req, WTA_ADDR_WTC);
    assign tick = (div_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= '0;
        else if (set_default || wtc_write || tick)
            div_r <= '0;
        else
            div_r <= div_r + 32'd1;
    end

    // A period is built from 10 ms ticks; the long range counts ten per step.
    assign sub_len = wtc_r[WTA_WTC_RANGE] ? 4'd1 : 4'(WTA_TICKS_LONG);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sub_cnt_r <= '0;
            tick_cnt_r <= '0;
        end
        else if (set_default || wtc_write)
        begin
            sub_cnt_r <= '0;
            tick_cnt_r <= '0;
        end
        else if (tick)
        begin
            if (sub_cnt_r == sub_len - 4'd1)
            begin
                sub_cnt_r <= '0;
                if (expire)
                    tick_cnt_r <= '0;
                else
                    tick_cnt_r <= tick_cnt_r + 4'd1;
            end
            else
                sub_cnt_r <= sub_cnt_r + 4'd1;
        end
    end

    // Expiry after code plus one steps.
    assign expire = tick && (sub_cnt_r == sub_len - 4'd1) &&
                    (tick_cnt_r == {1'b0, wtc_r[WTA_WTC_CODE_MSB:WTA_WTC_CODE_LSB]}); // see RQ10

    // ==========================================================================
    // Measurement and interrupts
    logic [7:0] ref_val;
    logic [7:0] abs_diff;
    logic over;
    logic meas_pending_r;
    logic amp_start_r;
    logic ph_start_r;
    logic irq_tmo_r;
    logic irq_amp_r;

    assign ref_val = cfg_r[WTA_CFG_AVG_SEL] ? avg : base_r; // see RQ17
    assign abs_diff = (amp_meas_result >= ref_val) ? amp_meas_result - ref_val
                                                   : ref_val - amp_meas_result; // see RQ21
    assign over = abs_diff > {4'h0, cfg_r[WTA_CFG_THR_MSB:WTA_CFG_THR_LSB]}; // see RQ14

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            amp_start_r <= 1'b0;
            ph_start_r <= 1'b0;
            irq_tmo_r <= 1'b0;
            irq_amp_r <= 1'b0;
            meas_pending_r <= 1'b0;
        end
        else
        begin
            amp_start_r <= expire && wtc_r[WTA_WTC_AMP]; // see RQ12
            ph_start_r <= expire && wtc_r[WTA_WTC_PHS]; // see RQ13
            irq_tmo_r <= expire && wtc_r[WTA_WTC_IRQ_TMO]; // see RQ11
            irq_amp_r <= meas_pending_r && amp_meas_done && over; // see RQ12
            if (set_default)
                meas_pending_r <= 1'b0;
            else if (expire && wtc_r[WTA_WTC_AMP])
                meas_pending_r <= 1'b1;
            else if (amp_meas_done)
                meas_pending_r <= 1'b0;
        end
    end

    assign amp_meas_start = amp_start_r;
    assign phase_meas_start = ph_start_r;
    assign irq_timeout = irq_tmo_r;
    assign irq_amplitude = irq_amp_r;

    // Excluding triggering samples keeps a nearby tag from dragging the baseline.
    wta_average u_avg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(set_default), // see RQ8
        .update(meas_pending_r && amp_meas_done && (!over || cfg_r[WTA_CFG_INCL])), // see RQ15
        .weight_sel(cfg_r[WTA_CFG_WGT_HI:WTA_CFG_WGT_LO]),
        .sample(amp_meas_result),
        .average(avg)
    );

endmodule

// File: sim/wta_chk.sv
// Port checker for the wake-up timer block.
`timescale 1ns/100ps
module wta_chk
    import wta_pkg::*;
#(
    parameter int TICK_CYCLES = 10
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic set_default,
    input wire wta_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire wta_status_t live_status,
    input wire logic amp_meas_start,
    input wire logic phase_meas_start,
    input wire logic amp_meas_done,
    input wire logic [7:0] amp_meas_result,
    input wire logic irq_timeout,
    input wire logic irq_amplitude
);
    logic [7:0] wtc_r;
    // ==========
    // Control shadow.
    // A pulse may trail a control write by one cycle, so both copies are accepted.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wtc_r <= 8'h00;
        else if (set_default)
            wtc_r <= 8'h00;
        else if (reg_req.we && reg_req.addr == WTA_ADDR_WTC)
            wtc_r <= reg_req.wdata;
    end
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    sequence rd_s(logic [7:0] a);
        reg_req.re && !set_default && reg_req.addr == a;
    endsequence
    sequence aux_s;
        rd_s(WTA_ADDR_AUX) ##0 $stable(live_status) && !$past(set_default);
    endsequence
    tmo_gap_a: assert property (irq_timeout |=> !irq_timeout [*8])
        else $error("timeout pulses too close");
    tmo_enable_a: assert property (irq_timeout |-> wtc_r[3] || $past(wtc_r[3]))
        else $error("timeout pulse while disabled");
    amp_enable_a: assert property (amp_meas_start |-> wtc_r[2] || $past(wtc_r[2]))
        else $error("amplitude start while disabled");
    phs_enable_a: assert property (phase_meas_start |-> wtc_r[1] || $past(wtc_r[1]))
        else $error("phase start while disabled");
    amp_irq_cause_a: assert property (irq_amplitude |-> $past(amp_meas_done))
        else $error("amplitude interrupt without result");
    aux_view_a: assert property (aux_s |=> reg_rdata == $past(live_status))
        else $error("status display differs from live bits");
    ctl_bit0_a: assert property (rd_s(WTA_ADDR_WTC) |=> !reg_rdata[0])
        else $error("control bit 0 reads one");
    unmapped_a: assert property (reg_req.re && !set_default && (reg_req.addr < WTA_ADDR_AUX
        || reg_req.addr > WTA_ADDR_AVG) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind wta_top wta_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .set_default(set_default), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .live_status(live_status), .amp_meas_start(amp_meas_start),
    .phase_meas_start(phase_meas_start), .amp_meas_done(amp_meas_done),
    .amp_meas_result(amp_meas_result), .irq_timeout(irq_timeout),
    .irq_amplitude(irq_amplitude));

// File: sim/wta_top_tb_top.sv
// Self-checking testbench for the wake-up timer block.
`timescale 1ns/100ps
module wta_top_tb_top
    import wta_pkg::*;
;
    // ==========
    // A short tick keeps the 800 ms period at 800 cycles.
    localparam int TK = 10;
    logic ref_clk = 0;
    logic nrst = 0;
    logic set_default = 0;
    logic amp_meas_done = 0;
    logic [7:0] amp_meas_result = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] bv = 8'h40;
    wta_reg_req_t reg_req = '0;
    wta_status_t live_status = '0;
    logic amp_meas_start, phase_meas_start, irq_timeout, irq_amplitude;
    logic [7:0] tmr [4] = '{8'h8a, 8'hfa, 8'h0a, 8'h7a};
    logic [15:0] amps [6] = '{16'h4044, 16'h4045, 16'h4b3b, 16'h0df5, 16'h0f10, 16'hf04f};
    int num_errors = 0;
    int n_checks = 0;
    int e = 0;
    always #12.5 ref_clk = ~ref_clk;
    wta_top #(.TICK_CYCLES(TK)) uut (.ref_clk(ref_clk), .nrst(nrst), .set_default(set_default),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .live_status(live_status),
        .amp_meas_start(amp_meas_start), .phase_meas_start(phase_meas_start),
        .amp_meas_done(amp_meas_done), .amp_meas_result(amp_meas_result),
        .irq_timeout(irq_timeout), .irq_amplitude(irq_amplitude));
    task stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task to(input int n);
        if (n > 2000)
        begin
            num_errors++;
            stop_test();
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        reg_req <= '0;
        @(negedge ref_clk);
        chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task wt(output int n, output int p);
        n = 0;
        p = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
            p += 32'(phase_meas_start);
            to(n);
        end
        while (irq_timeout !== 1'b1);
    endtask
    task amp(input logic [7:0] cfg, input logic [7:0] r);
        int i;
        int d;
        logic x;
        wr(WTA_ADDR_CFG, cfg);
        i = 0;
        do
        begin
            @(negedge ref_clk);
            i++;
            to(i);
        end
        while (amp_meas_start !== 1'b1);
        @(posedge ref_clk);
        amp_meas_done <= 1'b1;
        amp_meas_result <= r;
        @(posedge ref_clk);
        amp_meas_done <= 1'b0;
        @(negedge ref_clk);
        d = (cfg[0] ? e : int'(bv)) - int'(r);
        if (d < 0)
            d = -d;
        x = d > int'(cfg[7:4]);
        chk("irq_amplitude", 16'(irq_amplitude), 16'(x));
        if (!x || cfg[3])
            e = e + ((int'(r) - e) >>> (2 + cfg[2:1]));
        rd(WTA_ADDR_AVG, e[7:0]);
    endtask
    initial
    begin
        int n;
        int p;
        int i;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 6; i++)
            rd(WTA_ADDR_AUX + 8'(i), 8'h00);
        wr(WTA_ADDR_WTC, 8'hff);
        rd(WTA_ADDR_WTC, 8'hfe);
        wr(WTA_ADDR_CFG, 8'ha5);
        rd(WTA_ADDR_CFG, 8'ha5);
        wr(WTA_ADDR_BASE, 8'h5a);
        rd(WTA_ADDR_BASE, 8'h5a);
        wr(WTA_ADDR_AVG, 8'hff);
        rd(WTA_ADDR_AVG, 8'h00);
        wr(WTA_ADDR_AUX, 8'hff);
        rd(WTA_ADDR_AUX, 8'h00);
        for (i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            live_status <= 8'h80 >> i;
            rd(WTA_ADDR_AUX, 8'h80 >> i);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(WTA_ADDR_WTC, tmr[i]);
            // A pulse from the old setting may land on the write, so the third gap is timed.
            wt(n, p);
            wt(n, p);
            wt(n, p);
            chk("period", 16'(n), 16'((tmr[i][6:4] + 1) * (tmr[i][7] ? 1 : WTA_TICKS_LONG) * TK));
            chk("phase", 16'(p), 16'h0001);
        end
        wr(WTA_ADDR_WTC, 8'h84);
        wr(WTA_ADDR_BASE, bv);
        for (i = 0; i < 6; i++)
            amp(amps[i][15:8], amps[i][7:0]);
        @(posedge ref_clk);
        set_default <= 1'b1;
        live_status <= 8'h00;
        @(posedge ref_clk);
        set_default <= 1'b0;
        for (i = 0; i < 5; i++)
            rd(WTA_ADDR_AUX + 8'(i), 8'h00);
        stop_test();
    end
endmodule
